// File: lta_alarm_core.sv
// Operation
// - ten combining alarms, each with own settings and own state
// - a combining alarm takes at most four selected alarm states
// - and: true only when all configured inputs are true
// - nand: true when any configured input is false
// - or: true when any configured input is true
// - nor: true only when all configured inputs are false
// - xor: true only when exactly one configured input is true
// - a disabled alarm never goes active and drives no output
// - each alarm has priority high, medium, low or none for reporting
// - an active alarm drives its selected outputs: none, one, two, both
// - reject and flag a combining alarm that uses its own result
// - reject and flag a combining alarm with a duplicated source
// - reject and flag a combining alarm naming an invalid source
// - over: condition present while value exceeds pickup
// - under: condition present while value is below pickup
// - absolute over: magnitude exceeds pickup
// - absolute under: magnitude below pickup
// - trip only after pickup held for pickup delay, 0 to 999999 s
// - over alarm: dropout present while value below dropout setpoint
// - active alarm ends after dropout held for dropout delay
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "lta_cfg.svh"

module lta_alarm_core #(
  parameter int unsigned TICK_CYCLES = `LTA_TICK_CYC
) (
  input  wire logic               core_clk_i,
  input  wire logic               rstn_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [9:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic [7:0]         ext_alarm_i,
  input  wire logic signed [31:0] meas_value_i [`LTA_N_MEAS],
  output logic                    digital_output_one_o,
  output logic                    digital_output_two_o,
  output logic      [11:0]        alarm_active_o,
  output logic      [1:0]         alarm_level_o,
  output logic                    cfg_error_o
);

  localparam int NL = `LTA_N_LOGIC;
  localparam int NC = `LTA_N_CUST;
  localparam int NA = `LTA_N_ALARM;

  // ----------------------------------------------------------------
  // one-second tick
  // ----------------------------------------------------------------
  logic [26:0] tick_cnt_q;
  logic        tick_q;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 27'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 27'd1;
      tick_q     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // external alarm synchroniser
  // ----------------------------------------------------------------
  logic [7:0] ext_meta_q;
  logic [7:0] ext_q;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_meta_q <= '0;
      ext_q      <= '0;
    end else begin
      ext_meta_q <= ext_alarm_i;
      ext_q      <= ext_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic        wb_req;
  logic        wb_wr;
  logic [31:0] rd_data;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i;

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `LTA_RST_WORD;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : `LTA_RST_WORD;
    end
  end

  // ----------------------------------------------------------------
  // alarm state shared by all alarms
  // ----------------------------------------------------------------
  lta_pkg::lta_la_cfg_t la_cfg_q [NL];
  logic [31:0]          la_src_q [NL];
  lta_pkg::lta_ca_cfg_t ca_cfg_q [NC];
  logic signed [31:0]   ca_pick_q [NC];
  logic signed [31:0]   ca_drop_q [NC];
  logic [19:0]          ca_pdly_q [NC];
  logic [19:0]          ca_ddly_q [NC];
  logic [NL-1:0]        la_active_q;
  logic [NL-1:0]        la_err_q;
  logic [NC-1:0]        ca_active;
  logic [31:0]          src_vec;
  logic [NA-1:0]        act_vec;
  logic [NA-1:0]        sel1_vec;
  logic [NA-1:0]        sel2_vec;
  logic [NA-1:0]        en_vec;
  logic [1:0]           prio_vec [NA];

  assign src_vec = {12'h000, ext_q, ca_active, la_active_q};
  assign act_vec = {ca_active, la_active_q} & en_vec;

  // ----------------------------------------------------------------
  // combining alarms
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NL; i++) begin : g_la
    logic [31:0] cfg_w;
    logic [31:0] src_w;
    logic        self_err;
    logic        dup_err;
    logic        bad_err;
    logic [2:0]  n_in;
    logic [2:0]  n_true;
    logic        res;
    logic [4:0]  s;
    logic [4:0]  t;

    assign cfg_w = lane_merge({21'h0_0000, la_cfg_q[i]}, wb_dat_i, wb_sel_i);
    assign src_w = lane_merge(la_src_q[i], wb_dat_i, wb_sel_i);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        la_cfg_q[i] <= '0;
        la_src_q[i] <= `LTA_RST_WORD;
      end else if (wb_wr && wb_adr_i == `LTA_LA_CFG + 10'(i * 4)) begin
        la_cfg_q[i] <= lta_pkg::lta_la_cfg_t'(cfg_w[10:0]);
      end else if (wb_wr && wb_adr_i == `LTA_LA_SRC + 10'(i * 4)) begin
        la_src_q[i] <= src_w;
      end
    end

    always_comb begin
      self_err = 1'b0;
      dup_err  = 1'b0;
      bad_err  = (la_cfg_q[i].nin > 3'(`LTA_N_SLOT));
      n_in     = bad_err ? 3'd0 : la_cfg_q[i].nin;
      n_true   = 3'd0;
      s        = 5'h00;
      t        = 5'h00;
      for (int k = 0; k < `LTA_N_SLOT; k++) begin
        s = la_src_q[i][k*`LTA_SLOT_STEP +: 5];
        if (3'(k) < n_in) begin
          if (s == 5'(i)) self_err = 1'b1;
          if (s >= `LTA_SRC_END) bad_err = 1'b1;
          else if (src_vec[s]) n_true = n_true + 3'd1;
          for (int m = 0; m < k; m++) begin
            t = la_src_q[i][m*`LTA_SLOT_STEP +: 5];
            if (s == t) dup_err = 1'b1;
          end
        end
      end
      case (la_cfg_q[i].func)
        lta_pkg::LTA_F_AND:  res = (n_true == n_in);
        lta_pkg::LTA_F_NAND: res = (n_true != n_in);
        lta_pkg::LTA_F_OR:   res = (n_true != 3'd0);
        lta_pkg::LTA_F_NOR:  res = (n_true == 3'd0);
        lta_pkg::LTA_F_XOR:  res = (n_true == 3'd1);
        default:             res = 1'b0;
      endcase
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        la_err_q[i] <= 1'b0;
      end else begin
        la_err_q[i] <= self_err | dup_err | bad_err;
      end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        la_active_q[i] <= 1'b0;
      end else if (tick_q) begin
        la_active_q[i] <= la_cfg_q[i].en & ~(self_err | dup_err | bad_err)
                          & (n_in != 3'd0) & res;
      end
    end

    assign en_vec[i]   = la_cfg_q[i].en;
    assign sel1_vec[i] = la_cfg_q[i].outsel[0];
    assign sel2_vec[i] = la_cfg_q[i].outsel[1];
    assign prio_vec[i] = la_cfg_q[i].prio;

    chk_la_disabled: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      tick_q && !la_cfg_q[i].en |=> !la_active_q[i])
      else $error("disabled combining alarm went active");
    chk_self_ref: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      tick_q && self_err |=> la_err_q[i] && !la_active_q[i])
      else $error("self reference not rejected");
    chk_dup_source: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      dup_err |=> la_err_q[i])
      else $error("duplicate source not flagged");
    chk_bad_source: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      tick_q && bad_err |=> la_err_q[i] && !la_active_q[i])
      else $error("invalid source not rejected");
    chk_and_func: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      tick_q && la_cfg_q[i].en && la_cfg_q[i].func == lta_pkg::LTA_F_AND
      && n_in != 3'd0 && !(self_err || dup_err || bad_err)
      |=> la_active_q[i] == (n_true == n_in))
      else $error("and result wrong");
    chk_xor_func: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      tick_q && la_cfg_q[i].en && la_cfg_q[i].func == lta_pkg::LTA_F_XOR
      && n_true == 3'd2 |=> !la_active_q[i])
      else $error("xor true with two inputs");
    chk_hold_between: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !tick_q |=> $stable(la_active_q[i]))
      else $error("combining alarm changed off tick");
  end

  // ----------------------------------------------------------------
  // custom threshold alarms
  // ----------------------------------------------------------------
  for (genvar j = 0; j < NC; j++) begin : g_ca
    localparam logic [9:0] BASE = `LTA_CA_BASE + 10'(j) * `LTA_CA_STRIDE;
    logic [31:0]         cfg_w;
    logic [31:0]         dat_w;
    logic signed [32:0]  v;
    logic signed [32:0]  mag;
    logic signed [32:0]  pick;
    logic signed [32:0]  drop;
    logic                pu;
    logic                dr;
    lta_pkg::lta_state_t state_q;
    logic [19:0]         cnt_q;

    assign cfg_w = lane_merge({23'h00_0000, ca_cfg_q[j]}, wb_dat_i, wb_sel_i);
    assign dat_w = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        ca_cfg_q[j]  <= '0;
        ca_pick_q[j] <= '0;
        ca_drop_q[j] <= '0;
        ca_pdly_q[j] <= '0;
        ca_ddly_q[j] <= '0;
      end else if (wb_wr) begin
        if (wb_adr_i == BASE + `LTA_CA_CFG)
          ca_cfg_q[j] <= lta_pkg::lta_ca_cfg_t'(cfg_w[8:0]);
        if (wb_adr_i == BASE + `LTA_CA_PICK)
          ca_pick_q[j] <= lane_merge(ca_pick_q[j], wb_dat_i, wb_sel_i);
        if (wb_adr_i == BASE + `LTA_CA_DROP)
          ca_drop_q[j] <= lane_merge(ca_drop_q[j], wb_dat_i, wb_sel_i);
        if (wb_adr_i == BASE + `LTA_CA_PDLY)
          ca_pdly_q[j] <= (dat_w > 32'(`LTA_DLY_MAX)) ? `LTA_DLY_MAX : dat_w[19:0];
        if (wb_adr_i == BASE + `LTA_CA_DDLY)
          ca_ddly_q[j] <= (dat_w > 32'(`LTA_DLY_MAX)) ? `LTA_DLY_MAX : dat_w[19:0];
      end
    end

    always_comb begin
      v    = {meas_value_i[ca_cfg_q[j].msel][31], meas_value_i[ca_cfg_q[j].msel]};
      mag  = (v < 0) ? -v : v;
      pick = {ca_pick_q[j][31], ca_pick_q[j]};
      drop = {ca_drop_q[j][31], ca_drop_q[j]};
      case (ca_cfg_q[j].cond)
        lta_pkg::LTA_C_OVER: begin
          pu = (v > pick);
          dr = (v < drop);
        end
        lta_pkg::LTA_C_UNDER: begin
          pu = (v < pick);
          dr = (v > drop);
        end
        lta_pkg::LTA_C_ABS_OVER: begin
          pu = (mag > pick);
          dr = (mag < drop);
        end
        lta_pkg::LTA_C_ABS_UNDER: begin
          pu = (mag < pick);
          dr = (mag > drop);
        end
        default: begin
          pu = 1'b0;
          dr = 1'b0;
        end
      endcase
    end

    // qualifying delay: trips on the tick that finds the condition held
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        state_q <= lta_pkg::LTA_S_IDLE;
        cnt_q   <= '0;
      end else if (tick_q) begin
        if (!ca_cfg_q[j].en) begin
          state_q <= lta_pkg::LTA_S_IDLE;
          cnt_q   <= '0;
        end else begin
          case (state_q)
            lta_pkg::LTA_S_IDLE: begin
              if (!pu) cnt_q <= '0;
              else if (cnt_q >= ca_pdly_q[j]) begin
                state_q <= lta_pkg::LTA_S_TRIP;
                cnt_q   <= '0;
              end else cnt_q <= cnt_q + 20'd1;
            end
            lta_pkg::LTA_S_TRIP: begin
              if (!dr) cnt_q <= '0;
              else if (cnt_q >= ca_ddly_q[j]) begin
                state_q <= lta_pkg::LTA_S_IDLE;
                cnt_q   <= '0;
              end else cnt_q <= cnt_q + 20'd1;
            end
            default: begin
              state_q <= lta_pkg::LTA_S_IDLE;
              cnt_q   <= '0;
            end
          endcase
        end
      end
    end

    assign ca_active[j]     = (state_q == lta_pkg::LTA_S_TRIP);
    assign en_vec[NL+j]     = ca_cfg_q[j].en;
    assign sel1_vec[NL+j]   = ca_cfg_q[j].outsel[0];
    assign sel2_vec[NL+j]   = ca_cfg_q[j].outsel[1];
    assign prio_vec[NL+j]   = ca_cfg_q[j].prio;

    chk_pickup_wait: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      tick_q && state_q == lta_pkg::LTA_S_IDLE && cnt_q < ca_pdly_q[j]
      |=> state_q == lta_pkg::LTA_S_IDLE)
      else $error("custom alarm tripped before pickup delay");
    chk_dropout_wait: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      tick_q && ca_cfg_q[j].en && state_q == lta_pkg::LTA_S_TRIP
      && cnt_q < ca_ddly_q[j] |=> state_q == lta_pkg::LTA_S_TRIP)
      else $error("custom alarm ended before dropout delay");
    chk_zero_pickup: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      tick_q && ca_cfg_q[j].en && pu && ca_pdly_q[j] == 20'h0_0000
      && state_q == lta_pkg::LTA_S_IDLE |=> state_q == lta_pkg::LTA_S_TRIP)
      else $error("zero pickup delay did not trip");
  end

  // ----------------------------------------------------------------
  // outputs and reporting
  // ----------------------------------------------------------------
  logic [1:0] level;

  always_comb begin
    level = 2'b00;
    for (int n = 0; n < NA; n++) begin
      if (act_vec[n] && prio_vec[n] > level) level = prio_vec[n];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      digital_output_one_o <= 1'b0;
      digital_output_two_o <= 1'b0;
      alarm_active_o       <= '0;
      alarm_level_o        <= 2'b00;
      cfg_error_o          <= 1'b0;
    end else begin
      digital_output_one_o <= |(act_vec & sel1_vec);
      digital_output_two_o <= |(act_vec & sel2_vec);
      alarm_active_o       <= act_vec;
      alarm_level_o        <= level;
      cfg_error_o          <= |la_err_q;
    end
  end

  chk_output_one: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    |(act_vec & sel1_vec) |=> digital_output_one_o)
    else $error("output one not driven by active alarm");
  chk_output_idle: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (act_vec & sel2_vec) == '0 |=> !digital_output_two_o)
    else $error("output two driven with no active alarm");

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = `LTA_RST_WORD;
    if (wb_adr_i == `LTA_STATUS)
      rd_data = {18'h0_0000, level, act_vec};
    if (wb_adr_i == `LTA_ERROR)
      rd_data = {22'h00_0000, la_err_q};
    for (int i = 0; i < NL; i++) begin
      if (wb_adr_i == `LTA_LA_CFG + 10'(i * 4)) rd_data = {21'h0_0000, la_cfg_q[i]};
      if (wb_adr_i == `LTA_LA_SRC + 10'(i * 4)) rd_data = la_src_q[i];
    end
    for (int j = 0; j < NC; j++) begin
      if (wb_adr_i == `LTA_CA_BASE + 10'(j) * `LTA_CA_STRIDE + `LTA_CA_CFG)
        rd_data = {23'h00_0000, ca_cfg_q[j]};
      if (wb_adr_i == `LTA_CA_BASE + 10'(j) * `LTA_CA_STRIDE + `LTA_CA_PICK)
        rd_data = ca_pick_q[j];
      if (wb_adr_i == `LTA_CA_BASE + 10'(j) * `LTA_CA_STRIDE + `LTA_CA_DROP)
        rd_data = ca_drop_q[j];
      if (wb_adr_i == `LTA_CA_BASE + 10'(j) * `LTA_CA_STRIDE + `LTA_CA_PDLY)
        rd_data = {12'h000, ca_pdly_q[j]};
      if (wb_adr_i == `LTA_CA_BASE + 10'(j) * `LTA_CA_STRIDE + `LTA_CA_DDLY)
        rd_data = {12'h000, ca_ddly_q[j]};
    end
  end

  chk_ack_pulse: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule : lta_alarm_core

// File: lta_cfg.svh
`ifndef LTA_CFG_SVH
`define LTA_CFG_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define LTA_N_LOGIC    10
`define LTA_N_SLOT     4
`define LTA_N_CUST     2
`define LTA_N_EXT      8
`define LTA_N_MEAS     4
`define LTA_N_ALARM    12
`define LTA_DLY_W      20

// ----------------------------------------------------------------
// source index space
// ----------------------------------------------------------------
`define LTA_SRC_CUST   5'h0a
`define LTA_SRC_EXT    5'h0c
`define LTA_SRC_END    5'h14

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LTA_CLK_NS     10
`define LTA_TICK_NS    1_000_000_000
`define LTA_TICK_CYC   (`LTA_TICK_NS / `LTA_CLK_NS)
`define LTA_DLY_MAX    20'hf_423f

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define LTA_STATUS     10'h000
`define LTA_ERROR      10'h004
`define LTA_LA_CFG     10'h040
`define LTA_LA_SRC     10'h080
`define LTA_CA_BASE    10'h100
`define LTA_CA_STRIDE  10'h020
`define LTA_CA_CFG     10'h000
`define LTA_CA_PICK    10'h004
`define LTA_CA_DROP    10'h008
`define LTA_CA_PDLY    10'h00c
`define LTA_CA_DDLY    10'h010

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define LTA_ST_LVL_LSB 12
`define LTA_SLOT_STEP  8
`define LTA_RST_WORD   32'h0000_0000

`endif

// File: lta_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far side: alarm sources and measured values
// ----------------------------------------------------------------
module lta_far_model (
  input  wire logic               core_clk_i,
  input  wire logic [7:0]         ext_set_i,
  input  wire logic signed [31:0] meas_set_i,
  output logic      [7:0]         ext_alarm_o,
  output logic signed [31:0]      meas_value_o [4]
);
  logic [31:0] wob_q = 32'h0000_1234;
  // unused channels keep moving so nothing leans on a stale value
  always @(posedge core_clk_i) begin
    ext_alarm_o <= ext_set_i;
    wob_q       <= wob_q * 32'h0001_0dcd + 32'h0000_0001;
  end
  always_comb begin
    meas_value_o[0] = meas_set_i;
    for (int k = 1; k < 4; k++) meas_value_o[k] = wob_q ^ k;
  end
endmodule : lta_far_model

// File: lta_pkg.sv
package lta_pkg;

  typedef enum logic [2:0] {
    LTA_F_AND  = 3'b000,
    LTA_F_NAND = 3'b001,
    LTA_F_OR   = 3'b010,
    LTA_F_NOR  = 3'b011,
    LTA_F_XOR  = 3'b100
  } lta_func_t;

  typedef enum logic [1:0] {
    LTA_P_NONE = 2'b00,
    LTA_P_LOW  = 2'b01,
    LTA_P_MED  = 2'b10,
    LTA_P_HIGH = 2'b11
  } lta_prio_t;

  // bit 0 drives output one, bit 1 output two
  typedef enum logic [1:0] {
    LTA_O_NONE = 2'b00,
    LTA_O_ONE  = 2'b01,
    LTA_O_TWO  = 2'b10,
    LTA_O_BOTH = 2'b11
  } lta_out_t;

  typedef enum logic [1:0] {
    LTA_C_OVER      = 2'b00,
    LTA_C_UNDER     = 2'b01,
    LTA_C_ABS_OVER  = 2'b10,
    LTA_C_ABS_UNDER = 2'b11
  } lta_cond_t;

  typedef enum logic {
    LTA_S_IDLE = 1'b0,
    LTA_S_TRIP = 1'b1
  } lta_state_t;

  typedef struct packed {
    logic [2:0] nin;
    lta_out_t   outsel;
    lta_prio_t  prio;
    lta_func_t  func;
    logic       en;
  } lta_la_cfg_t;

  typedef struct packed {
    logic [1:0] msel;
    lta_out_t   outsel;
    lta_prio_t  prio;
    lta_cond_t  cond;
    logic       en;
  } lta_ca_cfg_t;

endpackage : lta_pkg

// File: tb_lta_alarm_core.sv
`timescale 1ns/1ps
module tb_lta_alarm_core;
  localparam int TK = 20;
  logic core_clk_i = 0, rstn_i = 0, cyc = 0, stb = 0, we = 0;
  logic [9:0]  adr = '0;
  logic [31:0] wdat = '0, rdat;
  logic [7:0]  ext_set = '0, ext;
  logic signed [31:0] meas_set = '0, meas [4];
  logic        ack, d1, d2, cerr, a, b, v, e;
  logic [11:0] act;
  logic [1:0]  lvl;
  logic [34:0] notes [$];
  logic [34:0] n;
  logic signed [31:0] vals [2] = '{32'hffff_ff38, 32'h0000_001e};
  logic [31:0] bad [3] = '{32'h0f0e_0d01, 32'h0f0e_0c0c, 32'h0f0e_0d14};
  int mismatches = 0, comparisons = 0, cycles = 0, seed = 32'h2b22, r;

  always #5 core_clk_i = ~core_clk_i;

  lta_alarm_core #(.TICK_CYCLES(TK)) i_lta_alarm_core (.core_clk_i(core_clk_i),
    .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_alarm_i(ext),
    .meas_value_i(meas), .digital_output_one_o(d1), .digital_output_two_o(d2),
    .alarm_active_o(act), .alarm_level_o(lvl), .cfg_error_o(cerr));
  lta_far_model i_lta_far_model (.core_clk_i(core_clk_i), .ext_set_i(ext_set),
    .meas_set_i(meas_set), .ext_alarm_o(ext), .meas_value_o(meas));

  // ----------------------------------------------------------------
  // checking and reporting
  // ----------------------------------------------------------------
  task automatic results;
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic check_out(input logic [14:0] got, input logic [14:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_out
  // read data, both digital outputs and cfg error, against the oldest note; level and active only on status reads
  always @(posedge core_clk_i) if (ack === 1'b1 && we === 1'b0) begin
    if (notes.size() == 0) n = '1;
    else n = notes.pop_front();
    check({rdat, d2, d1}, n[34:1]);
    if (adr == 10'h000) check_out({cerr, lvl, act}, {n[0], n[16:3]});
    else check_out({cerr, 14'h0000}, {n[0], 14'h0000});
  end
  always @(posedge core_clk_i) if (++cycles == 20000) begin
    mismatches++;
    results();
  end

  // ----------------------------------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [9:0] ad, input logic [31:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= ad; wdat <= d;
    do @(posedge core_clk_i); while (ack !== 1'b1);
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge core_clk_i);
  endtask : bus
  task automatic rd(input logic [9:0] ad, input logic [31:0] ex, input logic [1:0] dv,
                    input logic ce = 1'b0);
    notes.push_back({ex, dv, ce});
    bus(0, ad, 32'h0000_0000);
  endtask : rd
  task automatic tk(input int k);
    repeat (k * TK) @(posedge core_clk_i);
  endtask : tk
  task automatic cust(input logic [1:0] c, input logic signed [31:0] x, input logic t);
    bus(1, 10'h100, 32'h0000_0039 | {29'h0, c, 1'b0});
    meas_set <= x;
    tk(4);
    rd(10'h000, t ? 32'h0000_3400 : 32'h0000_0000, {1'b0, t});
  endtask : cust

  initial begin
    repeat (12) @(posedge core_clk_i);
    rstn_i <= 1;
    @(posedge core_clk_i);
    rd(10'h000, 32'h0000_0000, 2'b00);
    rd(10'h004, 32'h0000_0000, 2'b00);
    rd(10'h3fc, 32'h0000_0000, 2'b00);
    bus(1, 10'h080, 32'h0f0e_0d0c);
    for (int f = 0; f < 5; f++) for (int p = 0; p < 4; p++) begin
      r = $random(seed);
      ext_set <= {r[7:2], p[1:0]};
      bus(1, 10'h040, {21'h0, 3'd2, p[1:0], p[1:0], f[2:0], 1'b1});
      tk(3);
      a = p[0];
      b = p[1];
      v = (f == 0) ? a & b : (f == 1) ? !(a & b) : (f == 2) ? a | b : (f == 3) ? !(a | b) : a ^ b;
      rd(10'h000, v ? {18'h0, p[1:0], 12'h001} : 32'h0, v ? p[1:0] : 2'b00);
    end
    ext_set <= 8'hff;
    bus(1, 10'h040, 32'h0000_02c4);
    tk(3);
    rd(10'h000, 32'h0000_0000, 2'b00);
    bus(1, 10'h044, 32'h0000_0405);
    for (int k = 0; k < 3; k++) begin
      bus(1, 10'h084, bad[k]);
      tk(3);
      rd(10'h004, 32'h0000_0002, 2'b00, 1'b1);
      rd(10'h000, 32'h0000_0000, 2'b00, 1'b1);
    end
    ext_set <= 8'h00;
    bus(1, 10'h084, 32'h0f0e_0d0c);
    rd(10'h004, 32'h0000_0000, 2'b00);
    bus(1, 10'h104, 32'h0000_0064);
    bus(1, 10'h108, 32'h0000_0064);
    for (int c = 0; c < 4; c++) for (int i = 0; i < 2; i++) begin
      e = (c == 0) ? vals[i] > 100 : (c == 1) ? vals[i] < 100 :
          (c == 2) ? (vals[i] > 100 || vals[i] < -100) : (vals[i] < 100 && vals[i] > -100);
      cust(c[1:0], vals[i], e);
    end
    cust(2'b00, 32'h0000_001e, 1'b0);
    bus(1, 10'h108, 32'h0000_0032);
    bus(1, 10'h10c, 32'h0000_0002);
    bus(1, 10'h110, 32'h0000_0001);
    meas_set <= 32'h0000_00c8;
    repeat (25) @(posedge core_clk_i);
    rd(10'h000, 32'h0000_0000, 2'b00);
    tk(3);
    rd(10'h000, 32'h0000_3400, 2'b01);
    meas_set <= 32'h0000_0046;
    tk(4);
    rd(10'h000, 32'h0000_3400, 2'b01);
    meas_set <= 32'h0000_000a;
    repeat (12) @(posedge core_clk_i);
    rd(10'h000, 32'h0000_3400, 2'b01);
    tk(3);
    rd(10'h000, 32'h0000_0000, 2'b00);
    results();
  end
endmodule : tb_lta_alarm_core
